// File: design/sar_adc_pkg.sv
// Register map, field layout, reset values and timing counts of the converter control block
package sar_adc_pkg;
  // Register byte addresses
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_TRIG      = 8'h04;
  localparam logic [7:0] OFS_CFG       = 8'h08;
  localparam logic [7:0] OFS_COMPARE   = 8'h0C;
  localparam logic [7:0] OFS_RES_HIGH  = 8'h10;
  localparam logic [7:0] OFS_RES_LOW   = 8'h14;
  localparam logic [7:0] OFS_PIN_LOW   = 8'h18;
  localparam logic [7:0] OFS_PIN_MID   = 8'h1C;
  localparam logic [7:0] OFS_PIN_TOP   = 8'h20;
  localparam logic [7:0] OFS_PORT      = 8'h24;
  // Control register fields
  localparam int CTRL_CH_LSB   = 0;
  localparam int CTRL_CH_W     = 5;
  localparam int CTRL_CONT     = 5;
  localparam int CTRL_IRQ_EN   = 6;
  localparam int CTRL_DONE     = 7;
  localparam logic [4:0] CH_RESET = 5'h1F;
  // Trigger register fields
  localparam int TRIG_HW_EN    = 0;
  localparam int TRIG_CMP_EN   = 1;
  localparam int TRIG_CMP_GT   = 2;
  localparam int TRIG_ACTIVE   = 7;
  // Configuration fields
  localparam int CFG_CLK_LSB   = 0;
  localparam int CFG_MODE_LSB  = 2;
  localparam int CFG_LONG      = 4;
  localparam int CFG_DIV_LSB   = 5;
  localparam int CFG_LOWPWR    = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [1:0] CLK_BUS   = 2'h0;
  localparam logic [1:0] CLK_HALF  = 2'h1;
  localparam logic [1:0] CLK_ALT   = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  localparam logic [1:0] MODE_EIGHT = 2'h0;
  localparam logic [1:0] MODE_TEN   = 2'h2;
  // Converter timing, in converter clock ticks and bus cycles
  localparam logic [5:0] SAMPLE_SHORT = 6'h03;
  localparam logic [5:0] SAMPLE_LONG  = 6'h17;
  localparam logic [2:0] ASYNC_DIV    = 3'h4;
  localparam logic [3:0] TOP_BIT      = 4'hA;
  localparam logic [3:0] LAST_TEN     = 4'h0;
  localparam logic [3:0] LAST_EIGHT   = 4'h2;
  localparam int PINS = 24;
  // Conversion sequencer states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_SAMPLE  = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_FINISH  = 4'b1000
  } conv_state_t;
endpackage

// File: design/sar_adc_control.sv
// Successive approximation converter control with AXI4-Lite registers, pin control and trigger
//
// Overview of operation
// RQ1: Converter held idle during reset and while channel select is all ones.
// RQ2: Between single conversions the sequencer sits idle with converter power off.
// RQ3: Approximation yields eleven raw bits in ten-bit mode, nine in eight-bit.
// RQ4: Ten-bit mode rounds to ten bits across high and low result.
// RQ5: Eight-bit mode rounds to eight bits into low result only.
// RQ6: Result load sets done flag; interrupt follows when enabled.
// RQ7: Compare enable checks each result against compare value in all modes.
// RQ8: Four selectable input clocks, bus clock after reset.
// RQ9: Half bus clock source allows overall division up to sixteen.
// RQ10: Internal asynchronous clock keeps running in wait and stop.
// RQ11: Selected source divided by 1, 2, 4 or 8.
// RQ12: Analog-selected pin has its output driver forced off.
// RQ13: Analog-selected pin has input buffer off and reads zero.
// RQ14: Analog-selected pin has its pull-up disabled.
// RQ15: Middle pin register bits 0..7 serve channels 8..15.
// RQ16: Top pin register bits 0..7 serve channels 16..23.
// RQ17: With trigger enabled, each trigger rising edge while idle starts a conversion.
// RQ18: Trigger edges during a conversion are ignored.
// RQ19: In continuous mode only the launching trigger edge counts.
// RQ20: Clock select codes: bus, half bus, alternate, asynchronous.
// RQ21: Mode codes: 00 eight-bit, 10 ten-bit, others reserved.
// RQ22: Divide codes 00..11 give ratios 1, 2, 4, 8.
// RQ23: Trigger input is synchronised before edge detection.
`timescale 1ns/1ps
module sar_adc_control
  import sar_adc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output wire logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output wire logic              s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output wire logic              s_axi_arready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              alternateClockEn,
  input  wire logic              waitMode,
  input  wire logic              stopMode,
  input  wire logic              hwTriggerInput,
  input  wire logic              compIn,
  output logic      [10:0]       dacCode,
  output logic      [4:0]        analogChannel,
  output wire logic              converterPowerOn,
  output wire logic              asyncClockOn,
  output wire logic              irq,
  input  wire logic [PINS-1:0]   portOutEn,
  input  wire logic [PINS-1:0]   portPullEn,
  input  wire logic [PINS-1:0]   padIn,
  output wire logic [PINS-1:0]   padOutEn,
  output wire logic [PINS-1:0]   padPullEn,
  output wire logic [PINS-1:0]   padInEn,
  output wire logic [PINS-1:0]   portReadData
);
  import sar_adc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [4:0]  channelSelect;
  logic        contMode, doneIrqEn, doneFlag;
  logic        hwTrigEn, cmpEn, cmpGreater;
  logic [7:0]  cfg;
  logic [9:0]  compareValue;
  logic [1:0]  resultHigh;
  logic [7:0]  resultLow;
  logic [7:0]  pinSelLow, pinSelMid, pinSelTop;
  conv_state_t state;
  logic [10:0] sar;
  logic [3:0]  bitIdx;
  logic [5:0]  sampleCnt;
  logic        contLaunched;

  // Field decode
  wire [1:0] inputClockSelect = cfg[CFG_CLK_LSB +: 2];
  wire [1:0] convMode         = cfg[CFG_MODE_LSB +: 2];
  wire [1:0] clockDivSelect   = cfg[CFG_DIV_LSB +: 2];
  wire       tenBit           = (convMode == MODE_TEN); // RQ21
  wire       disabled         = (channelSelect == CH_RESET);
  wire [PINS-1:0] pinSel      = {pinSelTop, pinSelMid, pinSelLow}; // RQ15 RQ16

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data latched independently
  logic       awHeld, wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  wire       doWrite  = awHeld && wHeld && !s_axi_bvalid;
  wire       lowLane  = wStrb[0];
  wire       wrCtrl   = doWrite && lowLane && (awAddr == OFS_CTRL);
  wire       wrTrig   = doWrite && lowLane && (awAddr == OFS_TRIG);
  wire       wrCfg    = doWrite && lowLane && (awAddr == OFS_CFG);
  wire       wrCmp    = doWrite && (awAddr == OFS_COMPARE);
  wire       wrMapped = (awAddr <= OFS_PIN_TOP) && (awAddr[1:0] == 2'h0) && (awAddr != OFS_RES_HIGH)
                        && (awAddr != OFS_RES_LOW);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 8'h00;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only addresses answer SLVERR
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel, answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  wire rdTake = s_axi_arvalid && s_axi_arready;
  wire rdLowResult = rdTake && (s_axi_araddr == OFS_RES_LOW);
  logic [31:0] rdMux;
  logic        rdOk;
  always_comb begin
    rdOk  = 1'b1;
    rdMux = 32'h0000_0000;
    case (s_axi_araddr)
      OFS_CTRL:     rdMux[7:0] = {doneFlag, doneIrqEn, contMode, channelSelect};
      OFS_TRIG:     rdMux[7:0] = {!(state == ST_IDLE), 4'h0, cmpGreater, cmpEn, hwTrigEn};
      OFS_CFG:      rdMux[7:0] = cfg;
      OFS_COMPARE:  rdMux[9:0] = compareValue;
      OFS_RES_HIGH: rdMux[1:0] = resultHigh;
      OFS_RES_LOW:  rdMux[7:0] = resultLow;
      OFS_PIN_LOW:  rdMux[7:0] = pinSelLow;
      OFS_PIN_MID:  rdMux[7:0] = pinSelMid;
      OFS_PIN_TOP:  rdMux[7:0] = pinSelTop;
      OFS_PORT:     rdMux[PINS-1:0] = portReadData;
      default:      rdOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (rdTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= rdOk ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; any mode write aborts the conversion in flight
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      channelSelect <= CH_RESET;
      contMode      <= 1'b0;
      doneIrqEn     <= 1'b0;
      hwTrigEn      <= 1'b0;
      cmpEn         <= 1'b0;
      cmpGreater    <= 1'b0;
      cfg           <= CFG_RESET; // RQ8
      compareValue  <= 10'h000;
      pinSelLow     <= 8'h00;
      pinSelMid     <= 8'h00;
      pinSelTop     <= 8'h00;
    end else if (doWrite && lowLane) begin
      if (wrCtrl) begin
        channelSelect <= wData[CTRL_CH_LSB +: CTRL_CH_W];
        contMode      <= wData[CTRL_CONT];
        doneIrqEn     <= wData[CTRL_IRQ_EN];
      end
      if (wrTrig) begin
        hwTrigEn   <= wData[TRIG_HW_EN];
        cmpEn      <= wData[TRIG_CMP_EN]; // RQ7
        cmpGreater <= wData[TRIG_CMP_GT];
      end
      if (wrCfg) cfg <= wData[7:0];
      if (wrCmp) compareValue[7:0] <= wData[7:0];
      if (wrCmp && wStrb[1]) compareValue[9:8] <= wData[9:8];
      if (awAddr == OFS_PIN_LOW) pinSelLow <= wData[7:0];
      if (awAddr == OFS_PIN_MID) pinSelMid <= wData[7:0]; // RQ15
      if (awAddr == OFS_PIN_TOP) pinSelTop <= wData[7:0]; // RQ16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin control: an analog-selected pin loses driver, input and pull-up
  assign padOutEn     = portOutEn & ~pinSel;  // RQ12
  assign padInEn      = ~pinSel;              // RQ13
  assign portReadData = padIn & ~pinSel;      // RQ13
  assign padPullEn    = portPullEn & ~pinSel; // RQ14

  ////////////////////////////////////////////////////////////////////////////
  // Clock source pulses; only the internal source survives wait and stop
  logic       halfTick;
  logic [2:0] asyncCnt;
  wire  lowPower  = waitMode || stopMode;
  wire  asyncTick = (asyncCnt == ASYNC_DIV - 3'h1);
  logic srcTick;
  always_comb begin
    case (inputClockSelect) // RQ20
      CLK_BUS:  srcTick = !lowPower;
      CLK_HALF: srcTick = halfTick && !lowPower; // RQ9
      CLK_ALT:  srcTick = alternateClockEn && !lowPower;
      default:  srcTick = asyncTick; // RQ10
    endcase
  end

  // Divider by 1, 2, 4 or 8 in source pulses
  logic [2:0] divCnt;
  wire  [2:0] divTop  = 3'((4'h1 << clockDivSelect) - 4'h1); // RQ22
  wire        convTick = srcTick && (divCnt >= divTop);        // RQ11

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      halfTick <= 1'b0;
      asyncCnt <= 3'h0;
      divCnt   <= 3'h0;
    end else begin
      halfTick <= !halfTick;
      asyncCnt <= asyncTick ? 3'h0 : asyncCnt + 3'h1;
      if (convTick) divCnt <= 3'h0;
      else if (srcTick) divCnt <= divCnt + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger synchroniser; only the second and third flops feed the edge detector
  logic trigMeta, trigSync, trigLast;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trigMeta <= 1'b0;
      trigSync <= 1'b0;
      trigLast <= 1'b0;
    end else begin
      trigMeta <= hwTriggerInput; // RQ23
      trigSync <= trigMeta;
      trigLast <= trigSync;
    end
  end
  wire trigRise = trigSync && !trigLast; // RQ23

  // Start sources; a continuous run keeps later edges out
  wire swStart = wrCtrl && !hwTrigEn && (wData[CTRL_CH_LSB +: CTRL_CH_W] != CH_RESET);
  wire hwStart = hwTrigEn && trigRise && (state == ST_IDLE) && !contLaunched; // RQ17 RQ18 RQ19
  wire abort   = disabled || wrCtrl || wrTrig || wrCfg || wrCmp; // RQ1

  ////////////////////////////////////////////////////////////////////////////
  // Rounding and compare of the finished approximation
  wire [3:0]  lastBit  = tenBit ? LAST_TEN : LAST_EIGHT;
  wire [9:0]  round10  = (&sar[10:1]) ? sar[10:1] : sar[10:1] + {9'h000, sar[0]};  // RQ4
  wire [9:0]  round8   = {2'h0, (&sar[10:3]) ? sar[10:3] : sar[10:3] + {7'h00, sar[2]}}; // RQ5
  wire [9:0]  rounded  = tenBit ? round10 : round8;
  wire [9:0]  cmpRef   = tenBit ? compareValue : {2'h0, compareValue[7:0]};
  wire [9:0]  cmpDiff  = rounded - cmpRef;
  wire        geRef    = (rounded >= cmpRef);
  wire        cmpPass  = !cmpEn || (cmpGreater ? geRef : !geRef); // RQ7
  wire [9:0]  loadVal  = cmpEn ? cmpDiff : rounded;
  wire        transfer = (state == ST_FINISH) && cmpPass && !abort;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: sample, approximate MSB first, then load
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state        <= ST_IDLE;
      sar          <= 11'h000;
      bitIdx       <= 4'h0;
      sampleCnt    <= 6'h00;
      contLaunched <= 1'b0;
    end else if (abort && !swStart) begin
      state        <= ST_IDLE; // RQ1
      contLaunched <= 1'b0;
    end else if (swStart || hwStart) begin
      state        <= ST_SAMPLE;
      sampleCnt    <= 6'h00;
      contLaunched <= hwStart && contMode; // RQ19
    end else begin
      case (state)
        ST_SAMPLE: if (convTick) begin
          sampleCnt <= sampleCnt + 6'h01;
          if (sampleCnt == (cfg[CFG_LONG] ? SAMPLE_LONG : SAMPLE_SHORT)) begin
            state  <= ST_CONVERT;
            sar    <= 11'h400;
            bitIdx <= TOP_BIT;
          end
        end
        ST_CONVERT: if (convTick) begin
          // Keep the trial bit while the input is at or above the trial level
          if (!compIn) sar[bitIdx] <= 1'b0;
          if (bitIdx == lastBit) state <= ST_FINISH; // RQ3
          else begin
            sar[bitIdx - 4'h1] <= 1'b1;
            bitIdx <= bitIdx - 4'h1;
          end
        end
        ST_FINISH: begin
          state <= contMode ? ST_SAMPLE : ST_IDLE; // RQ2
          sampleCnt <= 6'h00;
          if (!contMode) contLaunched <= 1'b0;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Result registers and done flag; a new completion beats the clearing read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resultHigh <= 2'h0;
      resultLow  <= 8'h00;
      doneFlag   <= 1'b0;
    end else if (transfer) begin
      resultHigh <= tenBit ? loadVal[9:8] : 2'h0; // RQ4 RQ5
      resultLow  <= loadVal[7:0];
      doneFlag   <= 1'b1; // RQ6
    end else if (rdLowResult || wrCtrl) begin
      doneFlag   <= 1'b0;
    end
  end

  // Trial code straight from the approximation flops; a lagging copy would judge the previous trial
  assign dacCode = sar;

  // Channel to the analog mux; the sample phase outlasts this one-cycle lag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      analogChannel <= 5'h00;
    end else begin
      analogChannel <= channelSelect;
    end
  end
  assign converterPowerOn = (state != ST_IDLE); // RQ2
  assign asyncClockOn     = converterPowerOn && (inputClockSelect == CLK_ASYNC); // RQ10
  assign irq              = doneFlag && doneIrqEn; // RQ6

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_disabled_idle: assert property (@(posedge clk) disable iff (sys_rst) disabled && !swStart |=> state == ST_IDLE) // RQ1
    else $error("converter active while disabled");
  a_idle_after_done: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_FINISH && !contMode && !abort && !swStart && !hwStart |=> !converterPowerOn) // RQ2
    else $error("converter not idle after single conversion");
  a_raw_bits_count: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(state == ST_FINISH) |-> bitIdx == (tenBit ? LAST_TEN : LAST_EIGHT) && $past(convTick)) // RQ3
    else $error("wrong number of approximation steps");
  a_round_ten: assert property (@(posedge clk) disable iff (sys_rst)
    transfer && tenBit && !cmpEn |=> {resultHigh, resultLow} == $past(round10)) // RQ4
    else $error("ten-bit result misplaced");
  a_round_eight: assert property (@(posedge clk) disable iff (sys_rst)
    transfer && !tenBit && !cmpEn |=> resultHigh == 2'h0 && resultLow == $past(round8[7:0])) // RQ5
    else $error("eight-bit result misplaced");
  a_flag_irq: assert property (@(posedge clk) disable iff (sys_rst)
    transfer |=> doneFlag && (irq == doneIrqEn)) // RQ6
    else $error("done flag or interrupt missing");
  a_compare_block: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_FINISH && cmpEn && !cmpPass |=> $stable(resultLow) && $stable(resultHigh)) // RQ7
    else $error("failed compare loaded a result");
  a_div_ratio: assert property (@(posedge clk) disable iff (sys_rst || wrCfg || lowPower)
    convTick && inputClockSelect == CLK_BUS && clockDivSelect == 2'h3 && !lowPower && $stable(cfg)
    |=> !convTick [*7] ##1 convTick) // RQ11
    else $error("divide by eight spacing wrong");
  a_pin_isolate: assert property (@(posedge clk) disable iff (sys_rst)
    ((padOutEn | padPullEn | portReadData | padInEn) & pinSel) == {PINS{1'b0}}) // RQ12 RQ13 RQ14
    else $error("analog pin still under port control");
  a_trig_start: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(hwTriggerInput) && hwTrigEn && state == ST_IDLE && !contLaunched && !abort && !doWrite
    |-> ##3 (state == ST_SAMPLE)) // RQ17 RQ23
    else $error("trigger edge did not start conversion");
  a_trig_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    trigRise && state == ST_CONVERT && !doWrite |=> state != ST_SAMPLE || $past(convTick)) // RQ18
    else $error("trigger restarted a running conversion");

  c_single_done: cover property (@(posedge clk) disable iff (sys_rst) transfer && !contMode);
  c_hw_continuous: cover property (@(posedge clk) disable iff (sys_rst) hwStart && contMode);
  c_compare_fail: cover property (@(posedge clk) disable iff (sys_rst) state == ST_FINISH && !cmpPass);
  c_async_stop: cover property (@(posedge clk) disable iff (sys_rst) convTick && stopMode);
endmodule

// File: bench/analog_front_model.sv
// Analog input pins and external trigger source facing the converter
`timescale 1ns/1ps
module analog_front_model (
  input  wire logic [10:0] level [24],
  input  wire logic [10:0] dacCode,
  input  wire logic [4:0]  analogChannel,
  output logic             compIn,
  output logic             hwTrig
);
  // Ideal comparator; channels without a pin read as ground
  assign compIn = (analogChannel < 5'h18) && (level[analogChannel] >= dacCode);
  initial hwTrig = 1'h0;
  // Edge placed off the bus clock grid, as a real async source would be
  task automatic pulse(input int d);
    #(d * 1.3) hwTrig = 1'h1;
    #47 hwTrig = 1'h0;
  endtask
endmodule

// File: bench/sar_adc_control_pinmux_trigger_tb.sv
// Self-checking bench: registers, pin hand-over, conversions, trigger
`timescale 1ns/1ps
module sar_adc_control_pinmux_trigger_tb;
  import sar_adc_pkg::*;
  logic        clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, compIn, irq;
  logic        alternateClockEn, waitMode, stopMode, converterPowerOn, asyncClockOn, hwTriggerInput;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bres, rres, altCnt;
  logic [3:0]  s_axi_wstrb;
  logic [10:0] dacCode;
  logic [4:0]  analogChannel, ch;
  logic [23:0] portOutEn, portPullEn, padIn, padOutEn, padPullEn, padInEn, portReadData, sel;
  logic [10:0] level [24];
  logic [9:0]  ev;
  int          n_fail, cmp_count;

  sar_adc_control dut (
    .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .alternateClockEn, .waitMode, .stopMode,
    .hwTriggerInput, .compIn, .dacCode, .analogChannel, .converterPowerOn, .asyncClockOn, .irq, .portOutEn,
    .portPullEn, .padIn, .padOutEn, .padPullEn, .padInEn, .portReadData
  );
  analog_front_model fm (.level, .dacCode, .analogChannel, .compIn, .hwTrig(hwTriggerInput));

  ////////////////////////////////////////////////////////////////
  // Clock; alternate source ticks once in four bus cycles
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) altCnt <= altCnt + 2'h1;
  assign alternateClockEn = (altCnt == 2'h3);

  // Reference: ideal approximation of the level, then rounding
  function automatic logic [9:0] expv(input logic [10:0] l, input bit ten);
    int v;
    v = ten ? (l >> 1) + l[0] : (l >> 3) + l[2];
    if (v > (ten ? 1023 : 255)) v = ten ? 1023 : 255;
    return v[9:0];
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    bres = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rres = s_axi_rresp;
    s_axi_rready <= 1'h0;
    chk(nm, e, rv);
  endtask

  // Slowest source with long sampling needs about 1100 cycles
  task automatic waitIrq();
    for (int i = 0; i < 3000 && irq !== 1'h1; i++) @(posedge clk);
    chk("irq", 1'h1, irq);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'h1;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, waitMode, stopMode} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, portOutEn, portPullEn, padIn, altCnt} = '0;
    void'($urandom(32'h68864001));
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    chk("power", 1'h0, converterPowerOn);
    rchk("ctrl", OFS_CTRL, 32'h1F);
    rchk("cfg", OFS_CFG, 32'h0);
    rchk("unmapped", 8'h3C, 32'h0);
    chk("rresp", 2'h2, rres);
    wr(OFS_RES_LOW, 32'hFF);
    chk("bresp", 2'h2, bres);
    wr(OFS_CTRL, 32'h1F);
    repeat (20) @(posedge clk);
    chk("power", 1'h0, converterPowerOn);
    // Random pins handed to analog use, port side random too
    sel = 24'($urandom);
    wr(OFS_PIN_LOW, {24'h0, sel[7:0]});
    wr(OFS_PIN_MID, {24'h0, sel[15:8]});
    wr(OFS_PIN_TOP, {24'h0, sel[23:16]});
    portOutEn <= 24'($urandom);
    portPullEn <= 24'($urandom);
    padIn <= 24'($urandom);
    @(posedge clk);
    chk("padOutEn", {8'h0, portOutEn & ~sel}, {8'h0, padOutEn});
    chk("padPullEn", {8'h0, portPullEn & ~sel}, {8'h0, padPullEn});
    chk("padInEn", {8'h0, ~sel}, {8'h0, padInEn});
    rchk("port", OFS_PORT, {8'h0, padIn & ~sel});
    rchk("pin mid", OFS_PIN_MID, {24'h0, sel[15:8]});
    rchk("pin top", OFS_PIN_TOP, {24'h0, sel[23:16]});
    // Every source in both modes; async one runs in wait and stop
    for (int m = 0; m < 8; m++) begin
      ch = 5'($urandom_range(23));
      level[ch] <= 11'($urandom);
      waitMode <= (m[1:0] == CLK_ASYNC);
      stopMode <= (m[1:0] == CLK_ASYNC);
      wr(OFS_CFG, {25'h0, 2'($urandom), 1'($urandom), (m[2] ? MODE_TEN : MODE_EIGHT), m[1:0]});
      wr(OFS_CTRL, {24'h0, 3'h2, ch});
      chk("asyncClockOn", {31'h0, m[1:0] == CLK_ASYNC}, asyncClockOn);
      waitIrq();
      ev = expv(level[ch], m[2]);
      rchk("ctrl", OFS_CTRL, {24'h0, 3'h6, ch});
      rchk("res high", OFS_RES_HIGH, {30'h0, ev[9:8]});
      rchk("res low", OFS_RES_LOW, {24'h0, ev[7:0]});
      chk("irq", 1'h0, irq);
      chk("power", 1'h0, converterPowerOn);
    end
    // Hardware trigger, second run takes an extra edge mid conversion
    waitMode <= 1'h0;
    stopMode <= 1'h0;
    level[5] <= 11'h2D3;
    wr(OFS_CFG, 32'h68);
    wr(OFS_TRIG, 32'h1);
    wr(OFS_CTRL, 32'h45);
    repeat (8) @(posedge clk);
    chk("power", 1'h0, converterPowerOn);
    for (int k = 0; k < 2; k++) begin
      fm.pulse(3 + k);
      if (k == 1) repeat (20) @(posedge clk);
      if (k == 1) fm.pulse(2);
      waitIrq();
      rchk("res low", OFS_RES_LOW, 32'h6A);
    end
    repeat (300) @(posedge clk);
    chk("irq", 1'h0, irq);
    // Continuous run launched by one edge keeps converting on its own
    wr(OFS_CTRL, 32'h65);
    fm.pulse(3);
    for (int k = 0; k < 2; k++) begin
      waitIrq();
      rchk("res low", OFS_RES_LOW, 32'h6A);
    end
    wr(OFS_CTRL, 32'h45);
    // Compare limit unreachable, then always met
    wr(OFS_TRIG, 32'h6);
    wr(OFS_COMPARE, 32'h3FF);
    wr(OFS_CTRL, 32'h45);
    repeat (300) @(posedge clk);
    chk("irq", 1'h0, irq);
    wr(OFS_COMPARE, 32'h100);
    wr(OFS_CTRL, 32'h45);
    waitIrq();
    rchk("res low", OFS_RES_LOW, 32'h6A);
    rchk("res high", OFS_RES_HIGH, 32'h0);
    wrap_up();
  end
endmodule
